// file: design/abu_top.sv
// Address breakpoint unit: registers, break sequencing and side controls
// Summary of operation
// R1: Enabled address match raises breakpoint request
// R2: Break forces trap opcode, selects vector
// R3: Writing one to active bit breaks
// R4: Return from trap ends break state
// R5: Opcode match breaks before instruction executes
// R6: Operand match breaks after instruction completes
// R7: Software break taken before next instruction
// R8: Cleared active bit blocks repeat breaks
// R9: Flag clears in break need enable
// R10: Break halts first timer, blocks captures
// R11: Watchdog off in monitor break if set
// R12: Enable bit seven, reset clears it
// R13: Active bit set on match, write-zero clears
// R14: Break address two bytes, reset clears
// R15: Wait-exit flag shows break left wait
// R16: No break in wait or stop
// R17: Software reloads address per repeated break
// R18: Routine clears active bit before return
// R19: Place break address on opcodes
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module abu_top (
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // CPU side
   input wire logic [15:0] fetch_addr,
   input wire logic fetch_valid,
   input wire logic fetch_opcode,
   input wire logic insn_boundary,
   input wire logic trap_return,
   input wire logic monitor_mode,
   input wire logic wait_mode,
   input wire logic emulation_mode,
   output logic breakpoint_request,
   output logic [7:0] forced_opcode,
   output logic [15:0] trap_vector,
   output logic break_state,
   output logic flag_clear_allowed,
   output logic timer_halt,
   output logic watchdog_disable
);
   // Sequencer states
   // RUN: watching fetches; PEND: break owed at the next instruction
   // boundary; BREAK: trap routine in progress until return from trap
   typedef enum logic [1:0] {ST_RUN, ST_PEND, ST_BREAK} abu_state_t;

   // All state of the unit
   // One packed record keeps reset and next-state handling in one place
   typedef struct packed {
      abu_state_t st;            // Break sequencer
      logic enable;              // break_enable_bit
      logic active;              // break_active_flag
      logic [7:0] addr_hi;       // break_address_high
      logic [7:0] addr_lo;       // break_address_low
      logic wdog_off;            // watchdog_off_in_break
      logic flag_clear;          // flag_clear_in_break_enable
      logic wait_exit;           // wait_exit_by_break_flag
      logic armed;               // Match may still fire a break
      logic wr_pend;             // Write data phase pending
      logic rd_pend;             // Read data phase pending
      logic [7:0] reg_addr;      // Latched register offset
      logic [31:0] rdata;        // Registered read data
      logic req;                 // Registered breakpoint request
   } abu_regs_t;

   // Registered state and its next value
   abu_regs_t q, d;
   // Fetch bundle shared with the comparator
   abu_cpu_if cpu ();
   // Address phase of a word access to this slave
   logic addr_phase;
   // Only the low byte of write data reaches the 8-bit registers
   logic [7:0] wbyte;

   // Pass fetch information to the comparator
   // Opcode and boundary qualifiers travel along for the sequencer
   assign cpu.fetch_addr = fetch_addr;
   assign cpu.fetch_valid = fetch_valid;
   assign cpu.fetch_opcode = fetch_opcode;
   assign cpu.insn_boundary = insn_boundary;

   // Comparator instance
   // Armed is folded into the enable so a disarmed unit never sees a hit
   abu_matcher u_match (
      .bus(cpu.matcher),
      .enable(q.enable && q.armed),
      .break_addr({q.addr_hi, q.addr_lo})
   );

   // Address phase accepted this cycle; narrower sizes are ignored, as every
   // register is one aligned word and partial writes would need byte lanes
   assign addr_phase = hsel && hready && htrans == abu_pkg::HTRANS_NONSEQ &&
      hsize == abu_pkg::HSIZE_WORD;
   assign wbyte = hwdata[7:0];

   // Next-state logic
   // Bus writes are applied before the sequencer, so a match in the same cycle
   // as a write that clears the active bit still wins and sets the flag
   always_comb begin
      d = q;
      d.req = 1'b0;
      d.wr_pend = addr_phase && hwrite;
      d.rd_pend = addr_phase && !hwrite;
      if (addr_phase) begin
         d.reg_addr = haddr[7:0];
      end
      // Register writes in the data phase
      // The data phase uses the offset latched in the address phase
      if (q.wr_pend) begin
         unique case (q.reg_addr)
            abu_pkg::ADDR_STATUS_CONTROL: begin
               d.enable = wbyte[abu_pkg::BIT_ENABLE]; // R12
               if (wbyte[abu_pkg::BIT_ACTIVE]) begin
                  d.active = 1'b1; // R3
                  if (q.st == ST_RUN) begin
                     d.st = ST_PEND; // R7
                  end
               end else begin
                  // Clearing a set flag inside the routine disarms until the
                  // address is reloaded; a plain setup write leaves it armed
                  if (q.active) begin
                     d.armed = 1'b0; // R8
                  end
                  d.active = 1'b0; // R13
               end
            end
            abu_pkg::ADDR_BREAK_HIGH: begin
               d.addr_hi = wbyte; // R14
               d.armed = 1'b1; // R17
            end
            abu_pkg::ADDR_BREAK_LOW: begin
               d.addr_lo = wbyte; // R14
               d.armed = 1'b1;
            end
            abu_pkg::ADDR_AUXILIARY: d.wdog_off = wbyte[abu_pkg::BIT_WDOG_OFF];
            abu_pkg::ADDR_FLAG_CONTROL: d.flag_clear = wbyte[abu_pkg::BIT_FLAG_CLEAR];
            default: ;
         endcase
      end
      // Read data register
      // Unmapped offsets and the unused upper bits read as zero
      d.rdata = '0;
      if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            abu_pkg::ADDR_STATUS_CONTROL: begin
               d.rdata[abu_pkg::BIT_ENABLE] = q.enable;
               d.rdata[abu_pkg::BIT_ACTIVE] = q.active;
            end
            abu_pkg::ADDR_BREAK_HIGH: d.rdata[7:0] = q.addr_hi;
            abu_pkg::ADDR_BREAK_LOW: d.rdata[7:0] = q.addr_lo;
            abu_pkg::ADDR_AUXILIARY: d.rdata[abu_pkg::BIT_WDOG_OFF] = q.wdog_off;
            abu_pkg::ADDR_WAIT_STATUS: d.rdata[abu_pkg::BIT_WAIT_EXIT] = q.wait_exit; // R15
            abu_pkg::ADDR_FLAG_CONTROL: d.rdata[abu_pkg::BIT_FLAG_CLEAR] = q.flag_clear;
            default: ;
         endcase
      end
      // Break sequencer
      // A break already owed or in progress ignores further matches, so a
      // routine that touches the break address cannot nest breaks
      unique case (q.st)
         ST_RUN: begin
            if (cpu.hit) begin
               d.active = 1'b1; // R13
               if (cpu.fetch_opcode) begin
                  // Opcode match: the trap opcode replaces the fetched one,
                  // so the matched instruction never starts
                  d.req = 1'b1; // R5
                  d.st = ST_BREAK;
                  d.wait_exit = wait_mode && emulation_mode; // R15
               end else begin
                  // Operand match: the instruction runs to its end first
                  d.st = ST_PEND; // R6
               end
            end
         end
         ST_PEND: begin
            // Operand matches and software breaks wait for the instruction
            // boundary, so the trap lands before the next one starts  R6 R7
            if (cpu.insn_boundary) begin
               d.req = 1'b1; // R1
               d.st = ST_BREAK;
               d.wait_exit = wait_mode && emulation_mode; // R15
            end
         end
         ST_BREAK: begin
            // Wait-exit flag only means something within one break
            if (trap_return) begin
               d.st = ST_RUN; // R4
               d.wait_exit = 1'b0;
            end
         end
         default: d.st = ST_RUN;
      endcase
   end

   // State register
   // Reset loads constants only; armed starts set so a fresh address works
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0; // R11 R12 R13 R14
         q.st <= ST_RUN;
         q.armed <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs
   // Read data come from a register loaded in the address phase, so they
   // stand for the whole data phase
   assign hrdata = q.rdata;
   // No wait states and never an error: unmapped offsets read zero
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign breakpoint_request = q.req;
   assign forced_opcode = abu_pkg::SOFT_TRAP_OPCODE; // R2
   assign trap_vector = monitor_mode ? abu_pkg::VECTOR_MONITOR : abu_pkg::VECTOR_NORMAL; // R2
   assign break_state = (q.st == ST_BREAK);
   // The unit only grants clears; each module must honour the permission
   assign flag_clear_allowed = !break_state || q.flag_clear; // R9
   assign timer_halt = break_state; // R10
   // Watchdog keeps running outside monitor mode even with the bit set
   assign watchdog_disable = break_state && monitor_mode && q.wdog_off; // R11

   // Checks of break sequencing, register flags and the side controls

   // Request follows a pending boundary or an opcode match
   req_cause_a: assert property (@(posedge clk) disable iff (rst) // R1
      breakpoint_request |-> ($past(q.st) == ST_PEND && $past(insn_boundary)) ||
         ($past(q.st) == ST_RUN && $past(cpu.hit) && $past(fetch_opcode)))
      else $error("request without pending break");

   // Request is a single-cycle pulse
   req_pulse_a: assert property (@(posedge clk) disable iff (rst) // R1
      breakpoint_request |=> !breakpoint_request)
      else $error("request longer than one cycle");

   // Opcode match traps at once, before the instruction starts
   opcode_first_a: assert property (@(posedge clk) disable iff (rst) // R5
      q.st == ST_RUN && cpu.hit && cpu.fetch_opcode |=> breakpoint_request && break_state)
      else $error("opcode match did not trap at once");

   // Operand match waits for the instruction to end
   operand_wait_a: assert property (@(posedge clk) disable iff (rst) // R6
      q.st == ST_RUN && cpu.hit && !cpu.fetch_opcode |=> !breakpoint_request && q.st == ST_PEND)
      else $error("operand match trapped too early");

   // Writing one to the active bit owes a break
   soft_start_a: assert property (@(posedge clk) disable iff (rst) // R3
      q.wr_pend && q.reg_addr == abu_pkg::ADDR_STATUS_CONTROL && wbyte[abu_pkg::BIT_ACTIVE] &&
         q.st == ST_RUN && !cpu.hit |=> q.active && q.st == ST_PEND)
      else $error("software write did not owe a break");

   // An owed break is taken at the next instruction boundary
   soft_break_a: assert property (@(posedge clk) disable iff (rst) // R7
      q.st == ST_PEND && cpu.insn_boundary |=> breakpoint_request && break_state)
      else $error("owed break not taken at boundary");

   // Break persists until return
   break_hold_a: assert property (@(posedge clk) disable iff (rst) // R4
      break_state && !trap_return |=> break_state)
      else $error("break left without return");

   // Return from trap ends the break
   return_end_a: assert property (@(posedge clk) disable iff (rst) // R4
      break_state && trap_return |=> !break_state)
      else $error("break kept after return");

   // Timer halts from the very cycle the break is requested
   timer_halt_a: assert property (@(posedge clk) disable iff (rst) // R10
      $rose(break_state) |-> timer_halt && breakpoint_request)
      else $error("timer not halted");

   // Flags protected
   flag_guard_a: assert property (@(posedge clk) disable iff (rst) // R9
      break_state && !q.flag_clear |-> !flag_clear_allowed)
      else $error("flag clear not blocked");

   // Watchdog off only in break
   wdog_off_a: assert property (@(posedge clk) disable iff (rst) // R11
      watchdog_disable |-> break_state && q.wdog_off)
      else $error("watchdog disabled outside break");

   // Match sets the active bit and picks the path by fetch kind
   active_set_a: assert property (@(posedge clk) disable iff (rst) // R13
      q.st == ST_RUN && cpu.hit |=>
         q.active && q.st == ($past(cpu.fetch_opcode) ? ST_BREAK : ST_PEND))
      else $error("match did not set active");

   // Clearing a set active bit disarms the comparator
   active_disarm_a: assert property (@(posedge clk) disable iff (rst) // R8
      q.wr_pend && q.reg_addr == abu_pkg::ADDR_STATUS_CONTROL &&
         !wbyte[abu_pkg::BIT_ACTIVE] && q.active |=> !q.armed)
      else $error("active clear did not disarm");

   // A disarmed unit never matches
   armed_gate_a: assert property (@(posedge clk) disable iff (rst) // R8
      !q.armed |-> !cpu.hit)
      else $error("hit while disarmed");

   // Loading either address byte arms the comparator again
   addr_rearm_a: assert property (@(posedge clk) disable iff (rst) // R17
      q.wr_pend && (q.reg_addr == abu_pkg::ADDR_BREAK_HIGH ||
         q.reg_addr == abu_pkg::ADDR_BREAK_LOW) |=> q.armed)
      else $error("address load did not arm");

   // A cleared enable bit blocks every match
   enable_gate_a: assert property (@(posedge clk) disable iff (rst) // R12
      !q.enable |-> !cpu.hit)
      else $error("hit while disabled");

   // No match without a fetch
   no_idle_hit_a: assert property (@(posedge clk) disable iff (rst) // R16
      !fetch_valid |-> !cpu.hit)
      else $error("hit without fetch");

   // Wait-exit flag is taken at break entry
   wait_set_a: assert property (@(posedge clk) disable iff (rst) // R15
      breakpoint_request |-> q.wait_exit == $past(wait_mode && emulation_mode))
      else $error("wait exit flag wrong at entry");

   // Return clears the wait-exit flag
   wait_clear_a: assert property (@(posedge clk) disable iff (rst) // R15
      break_state && trap_return |=> !q.wait_exit)
      else $error("wait exit flag kept after return");

   // Monitor vector selection
   vector_sel_a: assert property (@(posedge clk) disable iff (rst) // R2
      monitor_mode |-> trap_vector == abu_pkg::VECTOR_MONITOR)
      else $error("wrong monitor vector");

   // Normal vector selection
   vector_norm_a: assert property (@(posedge clk) disable iff (rst) // R2
      !monitor_mode |-> trap_vector == abu_pkg::VECTOR_NORMAL)
      else $error("wrong normal vector");
endmodule : abu_top
`default_nettype wire

// file: design/abu_pkg.sv
// Package: register map, field positions and opcodes of the address breakpoint unit
package abu_pkg;
   // Register byte offsets on the AHB-Lite bus
   localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_BREAK_HIGH = 8'h04;
   localparam logic [7:0] ADDR_BREAK_LOW = 8'h08;
   localparam logic [7:0] ADDR_AUXILIARY = 8'h0C;
   localparam logic [7:0] ADDR_WAIT_STATUS = 8'h10;
   localparam logic [7:0] ADDR_FLAG_CONTROL = 8'h14;
   // Field positions
   localparam int BIT_ENABLE = 7;
   localparam int BIT_ACTIVE = 6;
   localparam int BIT_WDOG_OFF = 0;
   localparam int BIT_WAIT_EXIT = 1;
   localparam int BIT_FLAG_CLEAR = 7;
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Opcode forced into the instruction register on a break
   localparam logic [7:0] SOFT_TRAP_OPCODE = 8'h83;
   // Trap vectors, normal and monitor mode
   localparam logic [15:0] VECTOR_NORMAL = 16'hFFFC;
   localparam logic [15:0] VECTOR_MONITOR = 16'hFEFC;
   // AHB transfer type and size codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage : abu_pkg

// file: design/abu_cpu_if.sv
// Interface: CPU fetch side of the breakpoint unit, shared with the comparator
`timescale 1ns/1ps
`default_nettype none
interface abu_cpu_if;
   logic [15:0] fetch_addr;   // Address of CPU-generated fetch
   logic fetch_valid;         // Fetch on the bus this cycle
   logic fetch_opcode;        // Fetch is an opcode, not an operand
   logic insn_boundary;       // Next instruction is about to start
   logic hit;                 // Address match pulse
   modport matcher (input fetch_addr, input fetch_valid, output hit);
   modport core (output fetch_addr, output fetch_valid, input hit);
endinterface : abu_cpu_if
`default_nettype wire

// file: design/abu_matcher.sv
// Address comparator of the breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module abu_matcher (
   abu_cpu_if.matcher bus,
   input wire logic enable,
   input wire logic [15:0] break_addr
);
   // Only a live fetch can match; in wait/stop no fetch occurs, so no hit  R16
   assign bus.hit = enable && bus.fetch_valid && (bus.fetch_addr == break_addr); // R1
endmodule : abu_matcher
`default_nettype wire

// file: testbench/abu_cpu_model.sv
// CPU and system-integration stand-in: fetches, instruction boundaries, trap returns
`timescale 1ns/1ps
`default_nettype none
module abu_cpu_model (
   input wire logic clk,
   output logic [15:0] fetch_addr,
   output logic fetch_valid,
   output logic fetch_opcode,
   output logic insn_boundary,
   output logic trap_return,
   input wire logic breakpoint_request
);
   int traps = 0; // Trap entries forced so far
   // Idle bus before the first fetch
   initial begin
      fetch_addr = 16'h0000;
      fetch_valid = 1'b0;
      fetch_opcode = 1'b0;
      insn_boundary = 1'b0;
      trap_return = 1'b0;
   end
   // Each request loads the trap opcode once; the count stands for that
   always @(posedge clk) begin
      if (breakpoint_request === 1'b1) traps++;
   end
   // One instruction: a fetch, then the boundary once it has completed
   task automatic step(input logic [15:0] a, input logic op);
      fetch_addr <= a;
      fetch_valid <= 1'b1;
      fetch_opcode <= op;
      @(posedge clk);
      // Released bus shows the inverse so a stale match cannot hide
      fetch_addr <= ~a;
      fetch_valid <= 1'b0;
      insn_boundary <= 1'b1;
      @(posedge clk);
      insn_boundary <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : step
   // Return from the trap routine
   task automatic ret();
      trap_return <= 1'b1;
      @(posedge clk);
      trap_return <= 1'b0;
      @(posedge clk);
   endtask : ret
endmodule : abu_cpu_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench of the address breakpoint unit over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic monitor_mode = 1'b0, wait_mode = 1'b0, emulation_mode = 1'b0;
   logic hresp, req, bstate, fca, thalt, wdis, fv, fo, ib, tr;
   logic [7:0] fop;
   logic [15:0] fa, vec;
   int miscompares = 0, compares = 0, exp_traps = 0;
   always #20 clk = ~clk; // 25 MHz
   abu_top abu_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .fetch_addr(fa), .fetch_valid(fv),
      .fetch_opcode(fo), .insn_boundary(ib), .trap_return(tr), .monitor_mode(monitor_mode),
      .wait_mode(wait_mode), .emulation_mode(emulation_mode), .breakpoint_request(req),
      .forced_opcode(fop), .trap_vector(vec), .break_state(bstate),
      .flag_clear_allowed(fca), .timer_halt(thalt), .watchdog_disable(wdis));
   abu_cpu_model abu_cpu_model_i (.clk(clk), .fetch_addr(fa), .fetch_valid(fv),
      .fetch_opcode(fo), .insn_boundary(ib), .trap_return(tr), .breakpoint_request(req));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One single AHB transfer; address held until hready, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
         input logic [7:0] e);
      haddr <= {24'h00_0000, a};
      htrans <= abu_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= abu_pkg::HSIZE_WORD;
      hsel <= 1'b1;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do @(posedge clk); while (hready !== 1'b1);
      if (!w) chk(hrdata, {24'h00_0000, e});
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask : xfer
   // Trap count and break state after a step
   task automatic tchk(input logic b);
      chk(32'(abu_cpu_model_i.traps), 32'(exp_traps));
      chk({31'h0000_0000, bstate}, {31'h0000_0000, b});
   endtask : tchk
   // Verdict and end of run
   task automatic wrap_up();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // Hang guard, far beyond the under a hundred cycles the tests need
   initial begin
      #160000;
      miscompares++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) xfer(1'b0, 8'(4 * i), 8'h00, 8'h00);
      $display("reset values done");
      xfer(1'b1, abu_pkg::ADDR_BREAK_HIGH, 8'h12, 8'h00);
      xfer(1'b1, abu_pkg::ADDR_BREAK_LOW, 8'h34, 8'h00);
      xfer(1'b0, abu_pkg::ADDR_BREAK_HIGH, 8'h00, 8'h12);
      xfer(1'b1, abu_pkg::ADDR_STATUS_CONTROL, 8'h80, 8'h00);
      abu_cpu_model_i.step(16'h1234, 1'b1);
      exp_traps++;
      tchk(1'b1);
      xfer(1'b0, abu_pkg::ADDR_STATUS_CONTROL, 8'h00, 8'hC0);
      chk({24'h00_0000, fop}, {24'h00_0000, abu_pkg::SOFT_TRAP_OPCODE});
      chk({16'h0000, vec}, 32'h0000_FFFC);
      monitor_mode <= 1'b1;
      xfer(1'b1, abu_pkg::ADDR_AUXILIARY, 8'h01, 8'h00);
      chk({16'h0000, vec}, 32'h0000_FEFC);
      // A written bit lands at the data-phase edge; look one edge later
      @(posedge clk);
      chk({29'h0000_0000, thalt, wdis, fca}, 32'h0000_0006);
      xfer(1'b1, abu_pkg::ADDR_FLAG_CONTROL, 8'h80, 8'h00);
      @(posedge clk);
      chk({31'h0000_0000, fca}, 32'h0000_0001);
      xfer(1'b1, abu_pkg::ADDR_STATUS_CONTROL, 8'h80, 8'h00);
      abu_cpu_model_i.ret();
      tchk(1'b0);
      chk({30'h0000_0000, thalt, wdis}, 32'h0000_0000);
      abu_cpu_model_i.step(16'h1234, 1'b1);
      tchk(1'b0);
      $display("address break done");
      xfer(1'b1, abu_pkg::ADDR_BREAK_LOW, 8'h35, 8'h00);
      abu_cpu_model_i.step(16'h1235, 1'b0);
      exp_traps++;
      tchk(1'b1);
      xfer(1'b1, abu_pkg::ADDR_STATUS_CONTROL, 8'h00, 8'h00);
      abu_cpu_model_i.ret();
      abu_cpu_model_i.step(16'h1235, 1'b1);
      tchk(1'b0);
      xfer(1'b1, abu_pkg::ADDR_STATUS_CONTROL, 8'h40, 8'h00);
      abu_cpu_model_i.step(16'h0400, 1'b1);
      exp_traps++;
      tchk(1'b1);
      xfer(1'b1, abu_pkg::ADDR_STATUS_CONTROL, 8'h00, 8'h00);
      abu_cpu_model_i.ret();
      $display("software break done");
      wait_mode <= 1'b1;
      emulation_mode <= 1'b1;
      xfer(1'b1, abu_pkg::ADDR_STATUS_CONTROL, 8'hC0, 8'h00);
      abu_cpu_model_i.step(16'h0500, 1'b1);
      exp_traps++;
      tchk(1'b1);
      xfer(1'b0, abu_pkg::ADDR_WAIT_STATUS, 8'h00, 8'h02);
      xfer(1'b1, abu_pkg::ADDR_STATUS_CONTROL, 8'h00, 8'h00);
      abu_cpu_model_i.ret();
      xfer(1'b0, abu_pkg::ADDR_WAIT_STATUS, 8'h00, 8'h00);
      $display("wait exit done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
